/* hdl/mhbp_pkg.sv */
package mhbp_pkg;

  typedef logic [5:0]  addr_t;
  typedef logic [7:0]  data_t;
  typedef logic [15:0] cnt_t;
  typedef logic [1:0]  tick_cnt_t;

  // Strobe arrangements on the host side
  typedef enum logic [1:0] {
    MODE_SEPARATE,
    MODE_OVERLAP,
    MODE_NESTED
  } mhbp_mode_t;

  // Timing base
  localparam int CLK_PERIOD_NS     = 10;
  localparam int DEV_CLK_PERIOD_NS = 500;
  localparam cnt_t DEV_DIV_CYC     = cnt_t'(DEV_CLK_PERIOD_NS / CLK_PERIOD_NS);

  // Device side
  localparam int        REG_COUNT  = 64;
  localparam addr_t     MC_ADDR    = 6'h08;
  localparam data_t     REG_RESET  = 8'h00;
  localparam tick_cnt_t PROC_TICKS = 2'h2;
  localparam data_t     BUS_IDLE   = 8'hFF;

  // Host side times, in ns
  localparam int STEP_NS       = 100;
  localparam int OE_PULSE_NS   = 200;
  localparam int CSOE_NS       = 3 * DEV_CLK_PERIOD_NS + 200;
  localparam int READ_GAP_NS   = 3 * DEV_CLK_PERIOD_NS + 320;
  localparam int WRITE_GAP_NS  = (34 * DEV_CLK_PERIOD_NS) / 10;
  localparam int CSCS_NS       = 3 * DEV_CLK_PERIOD_NS;

  // Least times, rounded up to whole cycles
  localparam cnt_t STEP_CYC  = cnt_t'((STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t OE_CYC    = cnt_t'((OE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t CSOE_CYC  = cnt_t'((CSOE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t RGAP_CYC  = cnt_t'((READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t WGAP_CYC  = cnt_t'((WRITE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam cnt_t CSCS_CYC  = cnt_t'((CSCS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Host step sequence: steps 0..4, bit n is step n
  localparam int         STEP_LAST  = 4;
  localparam int         STEP_DATA  = 3;
  localparam logic [4:0] ALE_SEP    = 5'h02;
  localparam logic [4:0] CS_SEP     = 5'h18;
  localparam logic [4:0] ALE_OVL    = 5'h06;
  localparam logic [4:0] CS_OVL     = 5'h1C;
  localparam logic [4:0] ALE_NEST   = 5'h04;
  localparam logic [4:0] CS_NEST    = 5'h1E;

endpackage

/* hdl/mhbp_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mhbp_if;
  import mhbp_pkg::*;

  // Host strobes, active low except direction (high is read)
  logic       ale_n;
  logic       cs_n;
  logic       oe_n;
  logic       rd_wr;
  // Drivers of the shared bus
  data_t      dev_data_o;
  logic       dev_data_oe;
  data_t      host_data_o;
  logic       host_data_oe;
  // Resolved bus level
  logic [5:0] shared_addr_data_lines;
  logic [1:0] upper_data_lines;
  data_t      bus_level;

  // Undriven bus floats high
  assign bus_level = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : BUS_IDLE);
  assign shared_addr_data_lines = bus_level[5:0];
  assign upper_data_lines       = bus_level[7:6];

  modport device (
    input  ale_n,
    input  cs_n,
    input  oe_n,
    input  rd_wr,
    input  shared_addr_data_lines,
    input  upper_data_lines,
    output dev_data_o,
    output dev_data_oe
  );

  modport host (
    output ale_n,
    output cs_n,
    output oe_n,
    output rd_wr,
    output host_data_o,
    output host_data_oe,
    input  shared_addr_data_lines,
    input  upper_data_lines
  );

endinterface
`default_nettype wire

/* hdl/mhbp_device.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Low six lines: address, then data
// - Upper two lines carry data bits only
// - Latch low six lines on address strobe
// - Host sets direction for each select
// - Write select stores bus data in register
// - Read select fills output latch, bus idle
// - Output enable drives latch onto bus
// - Read data ready within 3 clk+300ns
// - Read: 3 clk+320ns before next latch
// - Motor command valid within 3.2 clk
// - Separate, overlapped and nested strobes work
// - Write: 3.4 clk before next latch
// - Three clk from select rise to fall
module mhbp_device (
  // Clock and reset
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  // Host port
  mhbp_if.device               port_if,
  // Core side
  output logic                 reg_wr_o,
  output mhbp_pkg::addr_t      reg_wr_addr_o,
  output mhbp_pkg::data_t      reg_wr_data_o,
  output mhbp_pkg::data_t      motor_command_outputs_o
);
  import mhbp_pkg::*;

  typedef struct packed {
    logic  ale_n;
    logic  cs_n;
    logic  oe_n;
    logic  rd_wr;
    data_t data;
  } mhbp_dpins_t;

  typedef enum {
    DS_IDLE,
    DS_PROC
  } mhbp_dstate_t;

  localparam mhbp_dpins_t PINS_IDLE = 12'hFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser

  mhbp_dpins_t pins_raw;
  mhbp_dpins_t meta_reg;
  mhbp_dpins_t meta_next;
  mhbp_dpins_t sync_reg;
  mhbp_dpins_t sync_next;
  mhbp_dpins_t prev_reg;
  mhbp_dpins_t prev_next;

  always_comb begin
    pins_raw.ale_n = port_if.ale_n;
    pins_raw.cs_n  = port_if.cs_n;
    pins_raw.oe_n  = port_if.oe_n;
    pins_raw.rd_wr = port_if.rd_wr;
    pins_raw.data  = {port_if.upper_data_lines, port_if.shared_addr_data_lines};
  end

  always_comb begin
    meta_next = pins_raw;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_reg <= PINS_IDLE;
      sync_reg <= PINS_IDLE;
      prev_reg <= PINS_IDLE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  // Select rising edge starts the access
  logic cs_rise;
  assign cs_rise = !prev_reg.cs_n && sync_reg.cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Device clock divider

  cnt_t div_reg;
  cnt_t div_next;
  logic tick;

  assign tick = (div_reg == DEV_DIV_CYC - 16'h0001);

  always_comb begin
    div_next = tick ? '0 : div_reg + 16'h0001;
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address latch

  addr_t addr_reg;
  addr_t addr_next;

  // Transparent while strobe low, frozen at its rise
  always_comb begin
    addr_next = addr_reg;
    if (!sync_reg.ale_n) begin
      addr_next = sync_reg.data[5:0];
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      addr_reg <= '0;
    end else begin
      addr_reg <= addr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access engine and register file

  mhbp_dstate_t state_reg;
  mhbp_dstate_t state_next;
  tick_cnt_t    ticks_reg;
  tick_cnt_t    ticks_next;
  logic         op_read_reg;
  logic         op_read_next;
  addr_t        op_addr_reg;
  addr_t        op_addr_next;
  data_t        op_data_reg;
  data_t        op_data_next;
  data_t        out_latch_reg;
  data_t        out_latch_next;
  logic         wr_reg;
  logic         wr_next;
  data_t        regs_reg [REG_COUNT];
  data_t        regs_next [REG_COUNT];

  always_comb begin
    state_next     = state_reg;
    ticks_next     = ticks_reg;
    op_read_next   = op_read_reg;
    op_addr_next   = op_addr_reg;
    op_data_next   = op_data_reg;
    out_latch_next = out_latch_reg;
    wr_next        = 1'b0;
    regs_next      = regs_reg;
    case (state_reg)
      DS_IDLE: begin
        // Direction and data sampled at the select rise
        if (cs_rise) begin
          state_next   = DS_PROC;
          ticks_next   = '0;
          op_read_next = sync_reg.rd_wr;
          op_addr_next = addr_reg;
          op_data_next = sync_reg.data;
        end
      end
      DS_PROC: begin
        // Two device clocks: inside both the read and motor deadlines
        if (tick) begin
          ticks_next = ticks_reg + 2'h1;
          if (ticks_reg == PROC_TICKS - 2'h1) begin
            state_next = DS_IDLE;
            if (op_read_reg) begin
              out_latch_next = regs_reg[op_addr_reg];
            end else begin
              regs_next[op_addr_reg] = op_data_reg;
              wr_next                = 1'b1;
            end
          end
        end
      end
      default: begin
        state_next = DS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg     <= DS_IDLE;
      ticks_reg     <= '0;
      op_read_reg   <= 1'b0;
      op_addr_reg   <= '0;
      op_data_reg   <= '0;
      out_latch_reg <= '0;
      wr_reg        <= 1'b0;
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_reg[i] <= REG_RESET;
      end
    end else begin
      state_reg     <= state_next;
      ticks_reg     <= ticks_next;
      op_read_reg   <= op_read_next;
      op_addr_reg   <= op_addr_next;
      op_data_reg   <= op_data_next;
      out_latch_reg <= out_latch_next;
      wr_reg        <= wr_next;
      regs_reg      <= regs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Bus driven while the synchronised output enable is low, two cycles behind the pin
  assign port_if.dev_data_oe = !sync_reg.oe_n;
  assign port_if.dev_data_o  = out_latch_reg;

  assign motor_command_outputs_o = regs_reg[MC_ADDR];
  assign reg_wr_o                = wr_reg;
  assign reg_wr_addr_o           = op_addr_reg;
  assign reg_wr_data_o           = op_data_reg;

endmodule
`default_nettype wire

/* hdl/mhbp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module mhbp_host (
  // Clock and reset
  input  wire logic            clock_i,
  input  wire logic            rst_i,
  // Device port
  mhbp_if.host                 port_if,
  // Request side
  input  wire logic            req_valid_i,
  input  wire logic            req_write_i,
  input  wire mhbp_pkg::addr_t req_addr_i,
  input  wire mhbp_pkg::data_t req_wdata_i,
  input  wire mhbp_pkg::mhbp_mode_t mode_i,
  output logic                 req_ready_o,
  // Answer side
  output logic                 rsp_valid_o,
  output mhbp_pkg::data_t      rsp_rdata_o
);
  import mhbp_pkg::*;

  typedef enum {
    HS_IDLE,
    HS_STEP,
    HS_AFTER
  } mhbp_hstate_t;

  ////////////////////////////////////////////////////////////////////////////
  // Bus synchroniser

  data_t meta_reg;
  data_t sync_reg;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_reg <= BUS_IDLE;
      sync_reg <= BUS_IDLE;
    end else begin
      meta_reg <= {port_if.upper_data_lines, port_if.shared_addr_data_lines};
      sync_reg <= meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobe sequencer

  mhbp_hstate_t state_reg;
  mhbp_hstate_t state_next;
  cnt_t         cnt_reg;
  cnt_t         cnt_next;
  logic [2:0]   step_reg;
  logic [2:0]   step_next;
  logic         write_reg;
  logic         write_next;
  addr_t        addr_reg;
  addr_t        addr_next;
  data_t        wdata_reg;
  data_t        wdata_next;
  mhbp_mode_t   mode_reg;
  mhbp_mode_t   mode_next;
  logic         ale_n_reg;
  logic         ale_n_next;
  logic         cs_n_reg;
  logic         cs_n_next;
  logic         oe_n_reg;
  logic         oe_n_next;
  logic         rd_wr_reg;
  logic         rd_wr_next;
  logic         drive_reg;
  logic         drive_next;
  data_t        dout_reg;
  data_t        dout_next;
  data_t        rdata_reg;
  data_t        rdata_next;
  logic         rsp_reg;
  logic         rsp_next;
  logic [4:0]   ale_mask;
  logic [4:0]   cs_mask;
  cnt_t         gap_cyc;

  // Three strobe arrangements
  always_comb begin
    case (mode_reg)
      MODE_OVERLAP: begin
        ale_mask = ALE_OVL;
        cs_mask  = CS_OVL;
      end
      MODE_NESTED: begin
        ale_mask = ALE_NEST;
        cs_mask  = CS_NEST;
      end
      default: begin
        ale_mask = ALE_SEP;
        cs_mask  = CS_SEP;
      end
    endcase
  end

  // Wait after the select rise before the next access
  always_comb begin
    gap_cyc = write_reg ? WGAP_CYC : RGAP_CYC;
    if (gap_cyc < CSCS_CYC) begin
      gap_cyc = CSCS_CYC;
    end
    // A read stays until its output enable pulse is over
    if (!write_reg && gap_cyc < CSOE_CYC + OE_CYC + 16'h0001) begin
      gap_cyc = CSOE_CYC + OE_CYC + 16'h0001;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 16'h0001;
    step_next  = step_reg;
    write_next = write_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    mode_next  = mode_reg;
    ale_n_next = 1'b1;
    cs_n_next  = 1'b1;
    oe_n_next  = 1'b1;
    rd_wr_next = rd_wr_reg;
    drive_next = drive_reg;
    dout_next  = dout_reg;
    rdata_next = rdata_reg;
    rsp_next   = 1'b0;
    case (state_reg)
      HS_IDLE: begin
        cnt_next = '0;
        if (req_valid_i) begin
          state_next = HS_STEP;
          step_next  = '0;
          write_next = req_write_i;
          addr_next  = req_addr_i;
          wdata_next = req_wdata_i;
          mode_next  = mode_i;
          rd_wr_next = !req_write_i;
          drive_next = 1'b1;
          dout_next  = {2'h0, req_addr_i};
        end
      end
      HS_STEP: begin
        if (cnt_reg == STEP_CYC - 16'h0001) begin
          cnt_next = '0;
          if (step_reg == 3'(STEP_LAST)) begin
            state_next = HS_AFTER;
          end else begin
            step_next = step_reg + 3'h1;
            if (step_next == 3'(STEP_DATA)) begin
              drive_next = write_reg;
              dout_next  = wdata_reg;
            end
          end
        end
        // Strobes follow the starting step, so the latch never sees write data
        if (state_next == HS_STEP) begin
          ale_n_next = !ale_mask[step_next];
          cs_n_next  = !cs_mask[step_next];
        end
      end
      HS_AFTER: begin
        // Data held one step past the select rise
        if (cnt_reg == STEP_CYC - 16'h0001) begin
          drive_next = 1'b0;
        end
        if (!write_reg && cnt_reg >= CSOE_CYC - 16'h0001 && cnt_reg < CSOE_CYC + OE_CYC - 16'h0001) begin
          oe_n_next = 1'b0;
        end
        if (!write_reg && cnt_reg == CSOE_CYC + OE_CYC - 16'h0001) begin
          rdata_next = sync_reg;
        end
        if (cnt_reg >= gap_cyc - 16'h0001) begin
          state_next = HS_IDLE;
          rsp_next   = 1'b1;
          cnt_next   = '0;
        end
      end
      default: begin
        state_next = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= HS_IDLE;
      cnt_reg   <= '0;
      step_reg  <= '0;
      write_reg <= 1'b0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      mode_reg  <= MODE_SEPARATE;
      ale_n_reg <= 1'b1;
      cs_n_reg  <= 1'b1;
      oe_n_reg  <= 1'b1;
      rd_wr_reg <= 1'b1;
      drive_reg <= 1'b0;
      dout_reg  <= '0;
      rdata_reg <= '0;
      rsp_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      step_reg  <= step_next;
      write_reg <= write_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      mode_reg  <= mode_next;
      ale_n_reg <= ale_n_next;
      cs_n_reg  <= cs_n_next;
      oe_n_reg  <= oe_n_next;
      rd_wr_reg <= rd_wr_next;
      drive_reg <= drive_next;
      dout_reg  <= dout_next;
      rdata_reg <= rdata_next;
      rsp_reg   <= rsp_next;
    end
  end

  assign port_if.ale_n        = ale_n_reg;
  assign port_if.cs_n         = cs_n_reg;
  assign port_if.oe_n         = oe_n_reg;
  assign port_if.rd_wr        = rd_wr_reg;
  assign port_if.host_data_oe = drive_reg;
  assign port_if.host_data_o  = dout_reg;
  assign req_ready_o          = (state_reg == HS_IDLE);
  assign rsp_valid_o          = rsp_reg;
  assign rsp_rdata_o          = rdata_reg;

endmodule
`default_nettype wire

/* bench/mhbp_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module mhbp_checker (
  // Clock and reset
  input wire logic            clock_i,
  input wire logic            rst_i,
  // Host strobes
  input wire logic            ale_n,
  input wire logic            cs_n,
  input wire logic            oe_n,
  input wire logic            rd_wr,
  // Bus drivers
  input wire mhbp_pkg::data_t dev_data_o,
  input wire logic            dev_data_oe,
  input wire mhbp_pkg::data_t host_data_o,
  input wire logic            host_data_oe
);
  import mhbp_pkg::*;
  ////////////////////////////////////////////////////////////////
  // Cycles since the last select rise, and its direction
  cnt_t cnt_reg;
  cnt_t cnt_next;
  logic cs_q_reg;
  logic seen_reg;
  logic seen_next;
  logic rd_reg;
  logic rd_next;

  always_comb begin
    cnt_next  = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h0001;
    seen_next = seen_reg;
    rd_next   = rd_reg;
    if (cs_n && !cs_q_reg) begin
      cnt_next  = 16'h0001;
      seen_next = 1'b1;
      rd_next   = rd_wr;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cnt_reg  <= 16'h0000;
      cs_q_reg <= 1'b1;
      seen_reg <= 1'b0;
      rd_reg   <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      cs_q_reg <= cs_n;
      seen_reg <= seen_next;
      rd_reg   <= rd_next;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_dev_oe;
    dev_data_oe == !$past(oe_n, 2);
  endproperty
  a_dev_oe: assert property (p_dev_oe) else $error("device drive does not follow output enable");
  property p_quiet_select;
    !cs_n |-> !dev_data_oe;
  endproperty
  a_quiet_select: assert property (p_quiet_select) else $error("device drives during select");
  property p_addr_phase;
    !ale_n |-> host_data_oe && host_data_o[7:6] == 2'h0;
  endproperty
  a_addr_phase: assert property (p_addr_phase) else $error("address phase not driven cleanly");
  property p_wr_data;
    $rose(cs_n) && !rd_wr |-> host_data_oe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write data gone at select rise");
  property p_dir_stable;
    !cs_n && !$past(cs_n) |-> $stable(rd_wr);
  endproperty
  a_dir_stable: assert property (p_dir_stable) else $error("direction moved in select");
  property p_cscs;
    $fell(cs_n) && seen_reg |-> cnt_reg >= CSCS_CYC;
  endproperty
  a_cscs: assert property (p_cscs) else $error("select spacing too short");
  property p_wgap;
    $fell(ale_n) && seen_reg && !rd_reg |-> cnt_reg >= WGAP_CYC;
  endproperty
  a_wgap: assert property (p_wgap) else $error("latch too soon after write");
  property p_rgap;
    $fell(ale_n) && seen_reg && rd_reg |-> cnt_reg >= RGAP_CYC;
  endproperty
  a_rgap: assert property (p_rgap) else $error("latch too soon after read");
  property p_latch_ready;
    seen_reg && rd_reg && cs_n && cnt_reg > 16'h00B4 |-> $stable(dev_data_o);
  endproperty
  a_latch_ready: assert property (p_latch_ready) else $error("read latch late");

  c_read: cover property ($rose(cs_n) && rd_wr);
  c_write: cover property ($rose(cs_n) && !rd_wr);
  c_drive: cover property ($rose(dev_data_oe));
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mhbp_pkg::*;
  typedef struct packed {logic wr; addr_t addr; data_t data; mhbp_mode_t mode;} mhbp_row_t;

  logic       clock_i;
  logic       rst_i;
  logic       req_valid_i;
  logic       req_write_i;
  addr_t      req_addr_i;
  data_t      req_wdata_i;
  mhbp_mode_t mode_i;
  logic       req_ready_o;
  logic       rsp_valid_o;
  data_t      rsp_rdata_o;
  logic       reg_wr_o;
  addr_t      reg_wr_addr_o;
  data_t      reg_wr_data_o;
  data_t      motor_command_outputs_o;
  int         mismatches;
  int         checks;
  int         cycles;
  int         wr_cnt;
  int         n;
  addr_t      wr_addr;
  data_t      wr_data;
  data_t      mc_exp;
  mhbp_row_t  cur;
  mhbp_row_t  rows [8] = '{'{1'b1, 6'h08, 8'hA5, MODE_SEPARATE}, '{1'b0, 6'h08, 8'hA5, MODE_SEPARATE},
                           '{1'b1, 6'h3F, 8'hC3, MODE_OVERLAP}, '{1'b0, 6'h3F, 8'hC3, MODE_OVERLAP},
                           '{1'b1, 6'h00, 8'h5A, MODE_NESTED}, '{1'b0, 6'h00, 8'h5A, MODE_NESTED},
                           '{1'b1, 6'h15, 8'h7E, mhbp_mode_t'(2'h3)}, '{1'b0, 6'h15, 8'h7E, MODE_NESTED}};

  mhbp_if mhbp_if_i ();
  mhbp_host mhbp_host_i (.clock_i(clock_i), .rst_i(rst_i), .port_if(mhbp_if_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .mode_i(mode_i),
    .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o));
  mhbp_device mhbp_device_i (.clock_i(clock_i), .rst_i(rst_i), .port_if(mhbp_if_i), .reg_wr_o(reg_wr_o),
    .reg_wr_addr_o(reg_wr_addr_o), .reg_wr_data_o(reg_wr_data_o),
    .motor_command_outputs_o(motor_command_outputs_o));
  mhbp_checker mhbp_checker_i (.clock_i(clock_i), .rst_i(rst_i), .ale_n(mhbp_if_i.ale_n), .cs_n(mhbp_if_i.cs_n),
    .oe_n(mhbp_if_i.oe_n), .rd_wr(mhbp_if_i.rd_wr), .dev_data_o(mhbp_if_i.dev_data_o),
    .dev_data_oe(mhbp_if_i.dev_data_oe), .host_data_o(mhbp_if_i.host_data_o),
    .host_data_oe(mhbp_if_i.host_data_oe));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_rsp();
    int k;
    for (k = 0; k < 400; k++) begin
      @(negedge clock_i);
      if (rsp_valid_o === 1'b1) break;
    end
    check(k < 400, "no answer");
  endtask

  task automatic request(input mhbp_row_t r);
    cur = r;
    @(negedge clock_i);
    req_valid_i = 1'b1;
    req_write_i = r.wr;
    req_addr_i  = r.addr;
    req_wdata_i = r.data;
    mode_i      = r.mode;
  endtask

  task automatic run_row(input mhbp_row_t r);
    n = wr_cnt;
    request(r);
    @(negedge clock_i);
    req_valid_i = 1'b0;
    wait_rsp();
    if (r.wr && r.addr == MC_ADDR) mc_exp = r.data;
    if (r.wr) check(wr_cnt == n + 1 && wr_addr === r.addr && wr_data === r.data, "write not stored");
    else check(rsp_rdata_o === r.data, "read data wrong");
    check(motor_command_outputs_o === mc_exp, "motor command wrong");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (reg_wr_o === 1'b1) begin
      wr_cnt  <= wr_cnt + 1;
      wr_addr <= reg_wr_addr_o;
      wr_data <= reg_wr_data_o;
    end
    if (cycles == 9000) begin
      mismatches++;
      print_verdict();
    end
  end

  // Wire view: address phase and read drive
  always @(negedge clock_i) begin
    if (mhbp_if_i.ale_n === 1'b0)
      check({mhbp_if_i.upper_data_lines, mhbp_if_i.shared_addr_data_lines} === {2'h0, cur.addr}, "bad address");
    if (mhbp_if_i.dev_data_oe === 1'b1 && !cur.wr)
      check(mhbp_if_i.bus_level === cur.data, "bad read drive");
  end

  initial begin
    rst_i       = 1'b1;
    req_valid_i = 1'b0;
    req_write_i = 1'b0;
    req_addr_i  = 6'h00;
    req_wdata_i = 8'h00;
    mode_i      = MODE_SEPARATE;
    mismatches  = 0;
    checks      = 0;
    cycles      = 0;
    wr_cnt      = 0;
    mc_exp      = 8'h00;
    cur         = '0;
    repeat (8) @(negedge clock_i);
    rst_i = 1'b0;
    check(motor_command_outputs_o === 8'h00 && req_ready_o === 1'b1 && rsp_valid_o === 1'b0, "reset state");
    repeat (4) @(negedge clock_i);
    run_row('{1'b0, 6'h2A, REG_RESET, MODE_SEPARATE});
    foreach (rows[i]) run_row(rows[i]);
    // Request held while busy must not be taken twice
    n = wr_cnt;
    request('{1'b1, MC_ADDR, 8'h11, MODE_OVERLAP});
    @(negedge clock_i);
    req_wdata_i = 8'h22;
    repeat (20) @(negedge clock_i);
    req_valid_i = 1'b0;
    wait_rsp();
    check(motor_command_outputs_o === 8'h11 && wr_cnt == n + 1, "busy request taken");
    mc_exp = 8'h11;
    // Reset in the middle of an access
    request('{1'b1, MC_ADDR, 8'h77, MODE_SEPARATE});
    @(negedge clock_i);
    req_valid_i = 1'b0;
    repeat (25) @(negedge clock_i);
    rst_i = 1'b1;
    repeat (4) @(negedge clock_i);
    rst_i  = 1'b0;
    mc_exp = 8'h00;
    check(motor_command_outputs_o === 8'h00 && req_ready_o === 1'b1, "second reset");
    repeat (4) @(negedge clock_i);
    run_row('{1'b0, MC_ADDR, REG_RESET, MODE_NESTED});
    print_verdict();
  end
endmodule
`default_nettype wire
